// *** dv/spcc_ctrl_assertions.sv ***
/* Port assertions for the control bank.
   Bound to spcc_ctrl; one clock, synchronous reset. */
`timescale 1ns/100ps
module spcc_ctrl_assertions (
  // Clock, reset, register port
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic reg_wr_i,
  input wire logic [spcc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [spcc_pkg::DATA_W-1:0] reg_wdata_i,
  // Outputs and their causes
  input wire logic aux_pin_one_o,
  input wire logic aux_pin_one_oe_o,
  input wire logic afe_power_down_i,
  input wire logic pin_zero_level_o,
  input wire logic pin_one_level_o,
  input wire logic sample_start_o,
  input wire logic fast_clk_en_o,
  input wire logic [7:0] fast_clock_trim_o,
  input wire logic [spcc_pkg::FREQ_W-1:0] fast_clock_freq_khz_o,
  input wire logic slot_a_update_i,
  input wire logic slot_b_update_i,
  input wire logic slot_a_write_o,
  input wire logic slot_b_write_o
);
  import spcc_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  wire wr_cfg = reg_wr_i && reg_addr_i == OFS_PIN_SYNC_CONFIG;
  wire wr_hold = reg_wr_i && reg_addr_i == OFS_DATA_HOLD_CLOCK_GATE;
  wire wr_trim = reg_wr_i && reg_addr_i == OFS_FAST_TRIM;
  // Level register lags the config bit by one more cycle
  sequence s_pin0_off;
    wr_cfg && !reg_wdata_i[1] ##1 !reg_wr_i ##1 1'b1;
  endsequence
  sequence s_pin1_off;
    wr_cfg && !reg_wdata_i[5] ##1 !reg_wr_i ##1 1'b1;
  endsequence
  a_trim_out: assert property (wr_trim |=>
    fast_clock_trim_o == 8'($past(reg_wdata_i))) else $error("trim");
  a_trim_freq: assert property (
    int'(fast_clock_freq_khz_o) == FAST_NOMINAL_KHZ + TRIM_STEP_KHZ *
    (int'($past(fast_clock_trim_o)) - int'(TRIM_DEFAULT)))
    else $error("freq");
  a_pin_oe: assert property (wr_cfg |=>
    aux_pin_one_oe_o == $past(reg_wdata_i[6])) else $error("oe");
  a_pin0_off: assert property (s_pin0_off |=>
    !pin_zero_level_o) else $error("pin zero level");
  a_pin1_off: assert property (s_pin1_off |=>
    !pin_one_level_o) else $error("pin one level");
  a_start_pulse: assert property (sample_start_o |=>
    !sample_start_o) else $error("start width");
  a_drive_low: assert property (!afe_power_down_i |->
    !aux_pin_one_o) else $error("pin one drive");
  a_slot_b: assert property (wr_hold |=> slot_b_write_o ==
    (slot_b_update_i && !$past(reg_wdata_i[2]))) else $error("slot b");
  a_slot_a: assert property (wr_hold |=> slot_a_write_o ==
    (slot_a_update_i && !$past(reg_wdata_i[1]))) else $error("slot a");
  a_clk_gate: assert property (wr_hold |=>
    fast_clk_en_o == $past(reg_wdata_i[0])) else $error("clock gate");
endmodule
bind spcc_ctrl spcc_ctrl_assertions spcc_ctrl_assertions_i (.core_clk_i,
  .srst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .aux_pin_one_o,
  .aux_pin_one_oe_o, .afe_power_down_i, .pin_zero_level_o, .pin_one_level_o,
  .sample_start_o, .fast_clk_en_o, .fast_clock_trim_o,
  .fast_clock_freq_khz_o, .slot_a_update_i, .slot_b_update_i,
  .slot_a_write_o, .slot_b_write_o);

// *** dv/spcc_ctrl_test.sv ***
/* Self-checking bench for the control bank.
   Assumes the front model supplies ticks and pin pulses. */
`timescale 1ns/100ps
module spcc_ctrl_test;
  import spcc_pkg::*;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, afe = 1'b0, ua = 1'b0, ub = 1'b0;
  logic [7:0] addr = 8'h00, t;
  logic [15:0] wdata = 16'h0000, div = 16'h0000, rdata, freq;
  logic [1:0] pulse = 2'h0, pin;
  logic slow, fast, pout, oe, start, clk_en, wa, wb, rd_seen = 1'b0;
  logic [15:0] cfg [3] = '{16'h2096, 16'h20B8, 16'h20BE};
  logic [31:0] seed = 32'h50927E34;
  logic [15:0] exp_q [$];
  int errors = 0, check_count = 0, n;
  // Pin one wire: ours while enabled, else the far side
  wire pin1_w = oe ? pout : pin[1];
  always #25 core_clk_i = ~core_clk_i;
  spcc_front_model spcc_front_model_i (.core_clk_i, .pulse_i(pulse),
    .slow_tick_o(slow), .fast_tick_o(fast), .pin_o(pin));
  spcc_ctrl spcc_ctrl_i (.core_clk_i, .srst_i, .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .aux_pin_zero_i(pin[0]), .aux_pin_one_i(pin1_w), .aux_pin_one_o(pout),
    .aux_pin_one_oe_o(oe), .pin_zero_level_o(), .pin_one_level_o(),
    .afe_power_down_i(afe), .sample_rate_divider_i(div),
    .sample_start_o(start), .slow_tick_i(slow), .fast_tick_i(fast),
    .fast_clk_en_o(clk_en), .fast_clock_trim_o(t),
    .fast_clock_freq_khz_o(freq), .slot_a_update_i(ua),
    .slot_b_update_i(ub), .slot_a_write_o(wa), .slot_b_write_o(wb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Reads note their expected word for the monitor
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [15:0] d);
    @(posedge core_clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge core_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic count_starts(input int cycles, exp, input string what);
    n = 0;
    repeat (cycles)
    begin
      @(posedge core_clk_i);
      #1;
      n += int'(start);
    end
    check(16'(n), 16'(exp), what);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    if (rd_seen)
      check(rdata, exp_q.pop_front(), "read");
    rd_seen <= rd;
  end
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    bus(0, OFS_FAST_TRIM, RST_FAST_TRIM);
    bus(0, OFS_PIN_SYNC_CONFIG, RST_PIN_SYNC_CONFIG);
    bus(0, OFS_PIN1_DRIVE_CAL_START, RST_PIN1_DRIVE_CAL_START);
    bus(0, OFS_DATA_HOLD_CLOCK_GATE, RST_DATA_HOLD_CLOCK_GATE);
    bus(0, 8'h00, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      if (i < 2)
        seed[7:0] = {8{i[0]}};
      bus(1, OFS_FAST_TRIM, seed[15:0]);
      bus(0, OFS_FAST_TRIM, seed[15:0]);
      check(16'(t), {8'h00, seed[7:0]}, "trim");
      check(freq, 16'(FAST_NOMINAL_KHZ + TRIM_STEP_KHZ *
        (int'(seed[7:0]) - int'(TRIM_DEFAULT))), "freq");
    end
    $display("trim done");
    bus(1, OFS_PIN_SYNC_CONFIG, 16'h20D0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1, OFS_PIN1_DRIVE_CAL_START, {9'h000, i[1], 6'h00});
      afe <= i[0];
      @(posedge core_clk_i);
      #1;
      check(16'({oe, pout}), {14'h0000, 1'b1, i[1] & i[0]},
        "drive");
    end
    $display("pin drive done");
    for (int i = 0; i < 3; i++)
    begin
      bus(1, OFS_PIN_SYNC_CONFIG, cfg[i]);
      repeat (4) @(posedge core_clk_i);
      pulse <= 2'h3;
      @(posedge core_clk_i);
      pulse <= 2'h0;
      count_starts(20, int'(i < 2), "pin trigger");
    end
    div <= 16'h0001;
    bus(1, OFS_PIN_SYNC_CONFIG, RST_PIN_SYNC_CONFIG);
    repeat (40) @(posedge core_clk_i);
    count_starts(160, 10, "internal trigger");
    $display("triggers done");
    for (int i = 1; i >= 0; i--)
    begin
      bus(1, OFS_DATA_HOLD_CLOCK_GATE, 16'(i));
      bus(1, OFS_PIN1_DRIVE_CAL_START, 16'h0020);
      repeat (30) @(posedge core_clk_i);
      check(16'(clk_en), 16'(i), "clock gate");
      bus(0, OFS_CLK_RATIO, 16'(4 * i));
      bus(1, OFS_PIN1_DRIVE_CAL_START, 16'h0000);
    end
    $display("calibration done");
    ua <= 1'b1;
    ub <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      bus(1, OFS_DATA_HOLD_CLOCK_GATE, 16'(i * 2));
      #1;
      check(16'({wb, wa}), 16'(~i & 3), "slot writes");
    end
    $display("freeze done");
    repeat (2) @(posedge core_clk_i);
    wrap_up();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    errors++;
    wrap_up();
  end
endmodule

// *** dv/spcc_front_model.sv ***
/* Far-side model: slow tick every fourth cycle, fast tick every cycle,
   six-cycle pin pulses on request. Assumes the bench clock. */
`timescale 1ns/100ps
module spcc_front_model (
  // Clock and requests
  input wire logic core_clk_i,
  input wire logic [1:0] pulse_i,
  // Far side
  output logic slow_tick_o,
  output logic fast_tick_o,
  output logic [1:0] pin_o
);
  logic [1:0] div_q = 2'h0;
  logic [2:0] hi0_q = 3'h0;
  logic [2:0] hi1_q = 3'h0;
  always_ff @(posedge core_clk_i)
  begin
    div_q <= div_q + 2'h1;
    hi0_q <= pulse_i[0] ? 3'h6 : hi0_q - 3'(hi0_q != 3'h0);
    hi1_q <= pulse_i[1] ? 3'h6 : hi1_q - 3'(hi1_q != 3'h0);
  end
  assign slow_tick_o = div_q == 2'h3;
  assign fast_tick_o = 1'b1;
  assign pin_o = {hi1_q != 3'h0, hi0_q != 3'h0};
endmodule

// *** rtl/spcc_ctrl.sv ***
/*
  Pin, sample trigger and fast-clock calibration control bank with its
  registers, reached over a simple word register port from the host
  interface. Assumes oscillator tick pulses and the slot update strobes
  are on core_clk_i; the two auxiliary pins are asynchronous.
*/
// Operation
// - Trim code 00 slowest, 98 default, FF fastest, monotonic between.
// - Each trim step moves the nominal 32 MHz clock about 109 kHz.
// - Config bit 6 enables the pin one output driver.
// - Config bit 5 enables the pin one input buffer.
// - Config bit 1 enables the pin zero input buffer.
// - Trigger select 00 times samples from slow clock and divider.
// - Select 01 uses pin zero, 10 pin one; 11 reserved.
// - Drive select bit 6: 0 drives low, 1 drives power-down signal.
// - Rising calibration start computes clock ratio, readable at 0x0A.
// - Hold bit 2 freezes slot B data registers.
// - Hold bit 1 freezes slot A data registers.
// - Hold register bit 0 gates the 32 MHz digital clock.
`timescale 1ns/100ps
module spcc_ctrl #(
  parameter int RATIO_WIDTH = spcc_pkg::RATIO_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [spcc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [spcc_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [spcc_pkg::DATA_W-1:0] reg_rdata_o,
  // Auxiliary pins
  input wire logic aux_pin_zero_i,
  input wire logic aux_pin_one_i,
  output logic aux_pin_one_o,
  output logic aux_pin_one_oe_o,
  output logic pin_zero_level_o,
  output logic pin_one_level_o,
  // Front end
  input wire logic afe_power_down_i,
  input wire logic [spcc_pkg::DIV_W-1:0] sample_rate_divider_i,
  output logic sample_start_o,
  // Clocks
  input wire logic slow_tick_i,
  input wire logic fast_tick_i,
  output logic fast_clk_en_o,
  output logic [7:0] fast_clock_trim_o,
  output logic [spcc_pkg::FREQ_W-1:0] fast_clock_freq_khz_o,
  // Slot data updates
  input wire logic slot_a_update_i,
  input wire logic slot_b_update_i,
  output logic slot_a_write_o,
  output logic slot_b_write_o
);
  import spcc_pkg::*;

  typedef struct packed {
    // Register words
    logic [15:0] trim;
    logic [15:0] cfg;
    logic [15:0] drv;
    logic [15:0] hold;
    // Calibration
    logic [RATIO_WIDTH-1:0] ratio;
    logic [RATIO_WIDTH-1:0] fast_cnt;
    spcc_cal_e cal;
    logic cal_prev;
    // Trigger, pins and outputs
    logic [DIV_W+1:0] slow_cnt;
    logic [1:0] pin_prev;
    logic sample;
    logic [FREQ_W-1:0] freq;
    logic [15:0] rdata;
  } spcc_ctrl_s;

  spcc_ctrl_s st_q, st_d;
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic [1:0] trig_sel;
  logic [1:0] pin_en;
  logic [1:0] pin_rise;
  logic cal_bit;
  logic fast_on;
  logic [DIV_W+1:0] period;
  logic signed [17:0] trim_delta;
  logic signed [17:0] freq_calc;
  logic fast_inc;
  logic [RATIO_WIDTH-1:0] fast_next;
  logic [15:0] ratio_word;

  assign pin_raw = {aux_pin_one_i, aux_pin_zero_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pin_sync
      spcc_sync3 spcc_sync3_i (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .pin_i(pin_raw[gi]),
        .level_o(pin_lvl[gi])
      );
    end
  endgenerate

  assign trig_sel = st_q.cfg[POS_TRIG_SEL_LO+1:POS_TRIG_SEL_LO];
  assign pin_en = {st_q.cfg[POS_PIN_ONE_IE], st_q.cfg[POS_PIN_ZERO_IE]};
  // Disabled input buffer reads as low and cannot trigger
  assign pin_rise = pin_lvl & pin_en & ~st_q.pin_prev;
  assign cal_bit = st_q.drv[POS_CAL_START];
  assign fast_on = st_q.hold[POS_FAST_CLK_ON];
  // Sample period is four slow ticks per divider count
  assign period = {sample_rate_divider_i, 2'b00};
  // Divider of zero stops internal sampling
  // Linear in the code, so the rate rises monotonically with it
  assign trim_delta = 18'(signed'({1'b0, st_q.trim[7:0]}))
    - 18'(signed'(TRIM_DEFAULT));
  assign freq_calc = 18'(FAST_NOMINAL_KHZ)
    + 18'(trim_delta * 18'(TRIM_STEP_KHZ));

  // Saturating count, so a long slow period cannot wrap
  assign fast_inc = fast_tick_i && fast_on && !(&st_q.fast_cnt);
  assign fast_next = st_q.fast_cnt + RATIO_WIDTH'(fast_inc);
  // Upper bits of the ratio word read as zero
  assign ratio_word = 16'(st_q.ratio);

  always_comb
  begin
    st_d = st_q;
    st_d.sample = 1'b0;
    st_d.pin_prev = pin_lvl & pin_en;
    st_d.cal_prev = cal_bit;
    st_d.freq = FREQ_W'(freq_calc);

    // Whole words stored, reserved bits kept as written
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_FAST_TRIM:
        begin
          st_d.trim = reg_wdata_i;
        end
        OFS_PIN_SYNC_CONFIG:
        begin
          st_d.cfg = reg_wdata_i;
        end
        OFS_PIN1_DRIVE_CAL_START:
        begin
          st_d.drv = reg_wdata_i;
        end
        OFS_DATA_HOLD_CLOCK_GATE:
        begin
          st_d.hold = reg_wdata_i;
        end
        default:
        begin
          // Ratio word and unmapped offsets ignore writes
        end
      endcase
    end

    if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_CLK_RATIO:
        begin
          st_d.rdata = ratio_word;
        end
        OFS_FAST_TRIM:
        begin
          st_d.rdata = st_q.trim;
        end
        OFS_PIN_SYNC_CONFIG:
        begin
          st_d.rdata = st_q.cfg;
        end
        OFS_PIN1_DRIVE_CAL_START:
        begin
          st_d.rdata = st_q.drv;
        end
        OFS_DATA_HOLD_CLOCK_GATE:
        begin
          st_d.rdata = st_q.hold;
        end
        default:
        begin
          st_d.rdata = 16'h0000;
        end
      endcase
    end

    // Sample trigger source
    case (trig_sel)
      TRIG_INTERNAL:
      begin
        if (slow_tick_i && period != '0)
        begin
          if (st_q.slow_cnt >= period - 1'b1)
          begin
            st_d.slow_cnt = '0;
            st_d.sample = 1'b1;
          end
          else
          begin
            st_d.slow_cnt = st_q.slow_cnt + 1'b1;
          end
        end
      end
      TRIG_PIN_ZERO:
      begin
        st_d.slow_cnt = '0;
        st_d.sample = pin_rise[0];
      end
      TRIG_PIN_ONE:
      begin
        st_d.slow_cnt = '0;
        st_d.sample = pin_rise[1];
      end
      default:
      begin
        // Reserved code produces no samples
        st_d.slow_cnt = '0;
      end
    endcase

    // Ratio: fast ticks over one slow period, started by a rising bit
    case (st_q.cal)
      SPCC_CAL_IDLE:
      begin
        if (cal_bit && !st_q.cal_prev)
        begin
          st_d.cal = SPCC_CAL_ALIGN;
        end
      end
      SPCC_CAL_ALIGN:
      begin
        st_d.fast_cnt = '0;
        if (slow_tick_i)
        begin
          st_d.cal = SPCC_CAL_COUNT;
        end
      end
      SPCC_CAL_COUNT:
      begin
        // Gated fast clock gives no ticks to count
        st_d.fast_cnt = fast_next;
        if (slow_tick_i)
        begin
          // Closing cycle's fast tick belongs to this period
          st_d.ratio = fast_next;
          st_d.cal = SPCC_CAL_IDLE;
        end
      end
      default:
      begin
        st_d.cal = SPCC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
      st_q.trim <= RST_FAST_TRIM;
      st_q.cfg <= RST_PIN_SYNC_CONFIG;
      st_q.drv <= RST_PIN1_DRIVE_CAL_START;
      st_q.hold <= RST_DATA_HOLD_CLOCK_GATE;
      st_q.cal <= SPCC_CAL_IDLE;
      st_q.freq <= FREQ_W'(FAST_NOMINAL_KHZ);
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;

  // Value always driven; the enable alone decides the pin
  assign aux_pin_one_oe_o = st_q.cfg[POS_PIN_ONE_OE];
  assign aux_pin_one_o = st_q.drv[POS_PIN_ONE_DRIVE_SEL]
    & afe_power_down_i;
  assign pin_zero_level_o = st_q.pin_prev[0];
  assign pin_one_level_o = st_q.pin_prev[1];

  assign sample_start_o = st_q.sample;
  assign fast_clk_en_o = fast_on;
  assign fast_clock_trim_o = st_q.trim[7:0];
  assign fast_clock_freq_khz_o = st_q.freq;

  assign slot_a_write_o = slot_a_update_i
    & ~st_q.hold[POS_SLOT_A_FREEZE];
  assign slot_b_write_o = slot_b_update_i
    & ~st_q.hold[POS_SLOT_B_FREEZE];

endmodule

// *** rtl/spcc_pkg.sv ***
/*
  Package for the pin, trigger and fast-clock calibration control bank:
  register offsets, field positions, reset values and state codes.
  Assumes a 16-bit register port with 8-bit register addresses.
*/
package spcc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int RATIO_W = 12;
  localparam int DIV_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_CLK_RATIO = 8'h0A;
  localparam logic [7:0] OFS_FAST_TRIM = 8'h4D;
  localparam logic [7:0] OFS_PIN_SYNC_CONFIG = 8'h4F;
  localparam logic [7:0] OFS_PIN1_DRIVE_CAL_START = 8'h50;
  localparam logic [7:0] OFS_DATA_HOLD_CLOCK_GATE = 8'h5F;

  // Reset values, reserved storage included
  localparam logic [15:0] RST_FAST_TRIM = 16'h0098;
  localparam logic [15:0] RST_PIN_SYNC_CONFIG = 16'h2090;
  localparam logic [15:0] RST_PIN1_DRIVE_CAL_START = 16'h0000;
  localparam logic [15:0] RST_DATA_HOLD_CLOCK_GATE = 16'h0000;

  // Field positions
  localparam int POS_PIN_ONE_OE = 6;
  localparam int POS_PIN_ONE_IE = 5;
  localparam int POS_TRIG_SEL_LO = 2;
  localparam int POS_PIN_ZERO_IE = 1;
  localparam int POS_PIN_ONE_DRIVE_SEL = 6;
  localparam int POS_CAL_START = 5;
  localparam int POS_SLOT_B_FREEZE = 2;
  localparam int POS_SLOT_A_FREEZE = 1;
  localparam int POS_FAST_CLK_ON = 0;

  // Trigger select codes
  localparam logic [1:0] TRIG_INTERNAL = 2'h0;
  localparam logic [1:0] TRIG_PIN_ZERO = 2'h1;
  localparam logic [1:0] TRIG_PIN_ONE = 2'h2;

  // Fast-clock trim: default code, nominal rate, step per code
  localparam logic [8:0] TRIM_DEFAULT = 9'h098;
  localparam int FAST_NOMINAL_KHZ = 32000;
  localparam int TRIM_STEP_KHZ = 109;
  localparam int FREQ_W = 16;

  typedef enum logic [1:0] {
    SPCC_CAL_IDLE = 2'b00,
    SPCC_CAL_ALIGN = 2'b01,
    SPCC_CAL_COUNT = 2'b10
  } spcc_cal_e;

endpackage

// *** rtl/spcc_sync3.sv ***
/*
  Three-stage pin synchroniser; the output changes once the second and
  third stages agree. Assumes an asynchronous input and a synchronous
  active-high reset.
*/
`timescale 1ns/100ps
module spcc_sync3 (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Pin and result
  input wire logic pin_i,
  output logic level_o
);
  import spcc_pkg::*;

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } spcc_sync_s;

  spcc_sync_s st_q, st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.stage = {st_q.stage[1:0], pin_i};
    // Stage 0 is only read by stage 1
    if (st_q.stage[1] == st_q.stage[2])
    begin
      st_d.level = st_q.stage[2];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

endmodule
